// file: rtl/irq_nmi_controller.sv
// interrupt controller: flags, enables, routing, tick divider, vectors
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
module irq_nmi_controller
   import irq_nmi_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic slow_clock_en,
   input wire logic halt_mode,
   input wire logic timer2_event,
   input wire logic timer1_event,
   input wire logic timer0_event,
   input wire logic timer0_stop_event,
   input wire logic timer0_stop_mode,
   input wire logic external_source,
   input wire logic irq_mask,
   input wire logic take_ack,
   input wire logic return_req,
   input wire logic [15:0] cur_pc,
   output logic irq_req,
   output logic nmi_req,
   output logic [15:0] pc_load,
   output logic pc_load_valid,
   output logic [5:0] src_taken
);
   logic [5:0] irq_enable_bits_ff;
   logic [5:0] irq_pending_flags_ff;
   logic [5:0] route_ff;
   tick_ctl_t tick_ff;
   logic [TAP_W-1:0] divider_tap_ff;
   logic [TAP_W-1:0] nxt_divider_tap;
   logic fast_tick_ff;
   logic slow_tick_ff;
   logic ext_prev_ff;
   logic [5:0] events;
   logic wr_acc;
   logic rd_acc;
   logic pend_wr;
   logic [5:0] active;
   logic [5:0] irq_lines;
   logic [5:0] nmi_lines;
   logic [5:0] nmi_prev_ff;
   logic [5:0] nmi_edge;
   logic nmi_hold_ff;
   logic [2:0] nmi_src_ff;
   logic irq_ff;
   logic nmi_ff;
   cpu_state_t state_ff;
   cpu_state_t nxt_state;
   logic [15:0] stack_ff [STACK_DEPTH];
   logic [3:0] sp_ff;
   logic [15:0] pc_load_ff;
   logic pc_valid_ff;
   logic [5:0] taken_ff;
   logic [31:0] prdata_ff;
   logic [31:0] nxt_prdata;
   logic addr_ok;
   logic pslverr_ff;
   logic [2:0] pick;
   logic pick_nmi;

   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign pend_wr = wr_acc & pstrb[0] & (paddr == PENDING_ADDR);
   assign addr_ok = (paddr == ENABLE_ADDR) || (paddr == PENDING_ADDR) ||
      (paddr == ROUTE_ADDR) || (paddr == TICKCTL_ADDR);

   // tap n toggles at slow/2^(n+1); its rising edge is the tick
   always_comb begin
      nxt_divider_tap = divider_tap_ff;
      if (slow_clock_en && !halt_mode) begin
         nxt_divider_tap = divider_tap_ff + 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divider_tap_ff <= '0;
         fast_tick_ff <= 1'b0;
         slow_tick_ff <= 1'b0;
      end else begin
         divider_tap_ff <= nxt_divider_tap;
         fast_tick_ff <= ~divider_tap_ff[fast_tap(tick_ff.fast_rate)] &
            nxt_divider_tap[fast_tap(tick_ff.fast_rate)];
         slow_tick_ff <= ~divider_tap_ff[slow_tap(tick_ff.slow_rate)] &
            nxt_divider_tap[slow_tap(tick_ff.slow_rate)];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_prev_ff <= 1'b0;
      end else begin
         ext_prev_ff <= external_source;
      end
   end

   always_comb begin
      events = '0;
      events[0] = timer2_event;
      events[1] = timer1_event;
      events[SRC_TIMER0] = timer0_stop_mode ? timer0_stop_event
         : timer0_event;
      events[SRC_FAST] = fast_tick_ff;
      events[SRC_SLOW] = slow_tick_ff;
      events[SRC_EXT] = tick_ff.edge_rising ?
         (external_source & ~ext_prev_ff) :
         (~external_source & ext_prev_ff);
   end

   // set wins over a simultaneous software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_pending_flags_ff <= '0;
      end else begin
         for (int i = 0; i < NSRC; i++) begin
            if (events[i]) begin
               irq_pending_flags_ff[i] <= 1'b1;
            end else if (pend_wr && !pwdata[i]) begin
               irq_pending_flags_ff[i] <= 1'b0;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_enable_bits_ff <= ENABLE_RST;
         route_ff <= ROUTE_RST;
         tick_ff.fast_rate <= FAST_RATE_RST;
         tick_ff.slow_rate <= SLOW_RATE_RST;
         tick_ff.edge_rising <= EDGE_RISING_RST;
      end else if (wr_acc && pstrb[0]) begin
         if (paddr == ENABLE_ADDR) begin
            irq_enable_bits_ff <= pwdata[5:0];
         end
         if (paddr == ROUTE_ADDR) begin
            route_ff <= pwdata[5:0];
         end
         if (paddr == TICKCTL_ADDR) begin
            tick_ff.fast_rate <= pwdata[FAST_LSB +: 3];
            tick_ff.slow_rate <= pwdata[SLOW_LSB +: 3];
            tick_ff.edge_rising <= pwdata[EDGE_BIT];
         end
      end
   end

   always_comb begin
      nxt_prdata = '0;
      unique case (paddr)
         ENABLE_ADDR: nxt_prdata[5:0] = irq_enable_bits_ff;
         PENDING_ADDR: nxt_prdata[5:0] = irq_pending_flags_ff;
         ROUTE_ADDR: nxt_prdata[5:0] = route_ff;
         TICKCTL_ADDR: nxt_prdata[6:0] = {tick_ff.edge_rising,
            tick_ff.slow_rate, tick_ff.fast_rate};
         default: nxt_prdata = '0;
      endcase
   end

   // zero-wait slave; read data registered in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_ff <= '0;
      end else if (psel && !penable && !pwrite) begin
         prdata_ff <= nxt_prdata;
      end
   end

   // error flag raised in the setup cycle so it stands in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pslverr_ff <= 1'b0;
      end else begin
         pslverr_ff <= psel & ~penable & ~addr_ok;
      end
   end

   assign prdata = prdata_ff;
   assign pready = 1'b1;
   assign pslverr = pslverr_ff;

   assign active = irq_pending_flags_ff & irq_enable_bits_ff;
   assign irq_lines = active & ~route_ff;
   assign nmi_lines = active & route_ff;
   assign nmi_edge = nmi_lines & ~nmi_prev_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nmi_prev_ff <= '0;
         nmi_hold_ff <= 1'b0;
         nmi_src_ff <= 3'h0;
      end else begin
         nmi_prev_ff <= nmi_lines;
         if (nmi_edge != '0 && !nmi_hold_ff) begin
            nmi_hold_ff <= 1'b1;
            nmi_src_ff <= prio_pick(nmi_edge);
         end else if (state_ff == ST_ENTER && pick_nmi) begin
            nmi_hold_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_ff <= 1'b0;
         nmi_ff <= 1'b0;
      end else begin
         irq_ff <= (irq_lines != '0) & ~irq_mask;
         nmi_ff <= nmi_hold_ff;
      end
   end

   assign irq_req = irq_ff;
   assign nmi_req = nmi_ff;
   assign pick_nmi = nmi_hold_ff;
   assign pick = pick_nmi ? nmi_src_ff : prio_pick(irq_lines);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_RUN: if (take_ack && (nmi_hold_ff || irq_lines != '0)) begin
            nxt_state = ST_ENTER;
         end
         ST_ENTER: nxt_state = ST_SERVICE;
         ST_SERVICE: if (return_req) begin
            nxt_state = ST_RUN;
         end
         default: nxt_state = ST_RUN;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_ff <= ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // return stack has no reset; only pushed entries are ever popped
   always_ff @(posedge pclk) begin
      if (state_ff == ST_ENTER) begin
         stack_ff[sp_ff[2:0]] <= cur_pc;
      end
   end

   // push on entry, pop on return; entry only from ST_RUN, so at most one entry is stacked
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_ff <= 4'h0;
         pc_load_ff <= PC_RST;
         pc_valid_ff <= 1'b0;
         taken_ff <= '0;
      end else begin
         pc_valid_ff <= 1'b0;
         taken_ff <= '0;
         if (state_ff == ST_ENTER) begin
            sp_ff <= sp_ff + 4'h1;
            pc_load_ff <= {5'h00, VECTOR_BASE + {7'h00, pick, 1'b0}};
            pc_valid_ff <= 1'b1;
            taken_ff[pick] <= 1'b1;
         end else if (state_ff == ST_SERVICE && return_req &&
               sp_ff != 4'h0) begin
            sp_ff <= sp_ff - 4'h1;
            pc_load_ff <= stack_ff[sp_ff[2:0] - 3'h1];
            pc_valid_ff <= 1'b1;
         end
      end
   end

   assign pc_load = pc_load_ff;
   assign pc_load_valid = pc_valid_ff;
   assign src_taken = taken_ff;

   property p_flag_holds;
      @(posedge pclk) disable iff (!presetn)
      irq_pending_flags_ff[0] && !(pend_wr && !pwdata[0])
         |=> irq_pending_flags_ff[0];
   endproperty
   a_flag_holds: assert property (p_flag_holds)
      else $error("flag dropped without clear");

   property p_set_disabled;
      @(posedge pclk) disable iff (!presetn)
      timer1_event && !irq_enable_bits_ff[1] |=> irq_pending_flags_ff[1];
   endproperty
   a_set_disabled: assert property (p_set_disabled)
      else $error("flag not set while disabled");

   property p_clear;
      @(posedge pclk) disable iff (!presetn)
      pend_wr && !pwdata[3] && !events[3] |=> !irq_pending_flags_ff[3];
   endproperty
   a_clear: assert property (p_clear)
      else $error("zero write did not clear");

   property p_ext_edge;
      @(posedge pclk) disable iff (!presetn)
      tick_ff.edge_rising && $rose(external_source)
         |=> irq_pending_flags_ff[SRC_EXT];
   endproperty
   a_ext_edge: assert property (p_ext_edge)
      else $error("rising edge missed");

   property p_halt_stop;
      @(posedge pclk) disable iff (!presetn)
      halt_mode |=> $stable(divider_tap_ff);
   endproperty
   a_halt_stop: assert property (p_halt_stop)
      else $error("divider ran in halt");

   property p_irq_needs_enable;
      @(posedge pclk) disable iff (!presetn)
      irq_req |-> $past(irq_lines) != '0;
   endproperty
   a_irq_needs_enable: assert property (p_irq_needs_enable)
      else $error("irq without enabled flag");

   property p_vector;
      @(posedge pclk) disable iff (!presetn)
      state_ff == ST_ENTER && !pick_nmi && irq_lines[0]
         |=> pc_load == 16'h07e0 && pc_load_valid;
   endproperty
   a_vector: assert property (p_vector)
      else $error("timer2 vector wrong");

   property p_return;
      @(posedge pclk) disable iff (!presetn)
      state_ff == ST_SERVICE && return_req && sp_ff != 4'h0
         |=> pc_load_valid && sp_ff == $past(sp_ff) - 4'h1;
   endproperty
   a_return: assert property (p_return)
      else $error("return did not pop the stack");

   property p_route;
      @(posedge pclk) disable iff (!presetn)
      (active & ~route_ff) == '0 |=> !irq_req;
   endproperty
   a_route: assert property (p_route)
      else $error("nmi routed source raised irq");

   property p_nmi_latch;
      @(posedge pclk) disable iff (!presetn)
      $rose(nmi_lines[1]) && !nmi_hold_ff |=> nmi_hold_ff ##1 nmi_req;
   endproperty
   a_nmi_latch: assert property (p_nmi_latch)
      else $error("nmi edge not latched");

   property p_entry_onehot;
      @(posedge pclk) disable iff (!presetn)
      state_ff == ST_ENTER |=> pc_load_valid && $onehot(src_taken);
   endproperty
   a_entry_onehot: assert property (p_entry_onehot)
      else $error("entry without vector load");

   property p_stop_mode;
      @(posedge pclk) disable iff (!presetn)
      timer0_stop_mode && !timer0_stop_event && !irq_pending_flags_ff[2]
         |=> !irq_pending_flags_ff[2];
   endproperty
   a_stop_mode: assert property (p_stop_mode)
      else $error("timer0 event flagged in stop mode");

   c_irq: cover property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_ENTER && !pick_nmi);
   c_nmi: cover property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_ENTER && pick_nmi);
   c_ret: cover property (@(posedge pclk) disable iff (!presetn)
      state_ff == ST_SERVICE && return_req);
   c_fast_tick: cover property (@(posedge pclk) disable iff (!presetn)
      fast_tick_ff && irq_enable_bits_ff[SRC_FAST]);
   c_slow_tick: cover property (@(posedge pclk) disable iff (!presetn)
      slow_tick_ff && irq_enable_bits_ff[SRC_SLOW]);
endmodule : irq_nmi_controller

// file: rtl/irq_nmi_pkg.sv
// package: constants and types for the interrupt controller
package irq_nmi_pkg;
   localparam int NSRC = 6;
   localparam logic [11:0] ENABLE_OFS = 12'h00c;
   localparam logic [11:0] PENDING_OFS = 12'h00d;
   localparam logic [11:0] ROUTE_OFS = 12'h00e;
   localparam logic [11:0] TICKCTL_OFS = 12'h00f;
   localparam logic [11:0] ENABLE_ADDR = {ENABLE_OFS[9:0], 2'b00};
   localparam logic [11:0] PENDING_ADDR = {PENDING_OFS[9:0], 2'b00};
   localparam logic [11:0] ROUTE_ADDR = {ROUTE_OFS[9:0], 2'b00};
   localparam logic [11:0] TICKCTL_ADDR = {TICKCTL_OFS[9:0], 2'b00};
   localparam logic [11:0] CPUCTL_ADDR = 12'h040;
   localparam logic [5:0] ENABLE_RST = 6'h00;
   localparam logic [5:0] ROUTE_RST = 6'h00;
   localparam logic [2:0] FAST_RATE_RST = 3'h3;
   localparam logic [2:0] SLOW_RATE_RST = 3'h0;
   localparam logic EDGE_RISING_RST = 1'b1;
   localparam int FAST_LSB = 0;
   localparam int SLOW_LSB = 3;
   localparam int EDGE_BIT = 6;
   localparam int SRC_TIMER0 = 2;
   localparam int SRC_FAST = 3;
   localparam int SRC_SLOW = 4;
   localparam int SRC_EXT = 5;
   localparam int TAP_W = 14;
   localparam logic [10:0] VECTOR_BASE = 11'h7e0;
   localparam logic [15:0] PC_RST = 16'h0000;
   localparam int STACK_DEPTH = 8;

   typedef struct packed {
      logic [2:0] fast_rate;
      logic [2:0] slow_rate;
      logic edge_rising;
   } tick_ctl_t;

   typedef enum logic [1:0] {
      ST_RUN = 2'b00,
      ST_ENTER = 2'b01,
      ST_SERVICE = 2'b11
   } cpu_state_t;

   // fast tick: 000=tap10 ... 111=tap0
   function automatic logic [3:0] fast_tap(input logic [2:0] sel);
      logic [3:0] t;
      t = 4'h0;
      case (sel)
         3'h0: t = 4'ha;
         3'h1: t = 4'h8;
         3'h2: t = 4'h6;
         3'h3: t = 4'h4;
         3'h4: t = 4'h3;
         3'h5: t = 4'h2;
         3'h6: t = 4'h1;
         3'h7: t = 4'h0;
         default: t = 4'h0;
      endcase
      return t;
   endfunction : fast_tap

   function automatic logic [3:0] slow_tap(input logic [2:0] sel);
      return 4'hd - {1'b0, sel};
   endfunction : slow_tap

   // index of lowest set bit, timer2 (bit 0) is highest priority
   function automatic logic [2:0] prio_pick(input logic [5:0] req);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : prio_pick
endpackage : irq_nmi_pkg

// file: verif/cpu_model.sv
// behavioural processor core: takes requests, saves pc, returns
`timescale 1ns/1ps
module cpu_model (
   input wire logic pclk,
   input wire logic irq_req,
   input wire logic nmi_req,
   input wire logic [15:0] pc_load,
   input wire logic pc_load_valid,
   input wire logic [5:0] src_taken,
   output logic irq_mask = 1'b0,
   output logic take_ack = 1'b0,
   output logic return_req = 1'b0,
   output logic [15:0] cur_pc = 16'h0000
);
   task automatic wait_ld(output logic ok);
      int n;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pc_load_valid !== 1'b1 && n < 8);
      ok = n < 8;
   endtask : wait_ld
   // i-flag set on entry keeps further irqs off until return
   task automatic enter(input logic [15:0] pc, output logic [15:0] vec,
         output logic [5:0] src, output logic ok);
      int n;
      n = 0;
      while (irq_req !== 1'b1 && nmi_req !== 1'b1 && n < 64) begin
         @(posedge pclk);
         n++;
      end
      take_ack <= 1'b1;
      cur_pc <= pc;
      irq_mask <= 1'b1;
      @(posedge pclk);
      take_ack <= 1'b0;
      wait_ld(ok);
      vec = pc_load;
      src = src_taken;
      cur_pc <= ~pc;
   endtask : enter
   task automatic leave(output logic [15:0] pc, output logic ok);
      return_req <= 1'b1;
      @(posedge pclk);
      return_req <= 1'b0;
      wait_ld(ok);
      pc = pc_load;
      irq_mask <= 1'b0;
   endtask : leave
endmodule : cpu_model

// file: verif/test_irq_nmi_controller.sv
// self-checking bench for the interrupt controller
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin n_fail++; \
   $display("unexpected %s exp %h got %h", nm, e, s); end end
module test_irq_nmi_controller;
   import irq_nmi_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, er, irq_req, nmi_req, ok;
   logic [11:0] paddr = 12'h000;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] pwdata = 32'h0, prdata, rd, m, flg = 32'h0;
   logic slow_clock_en = 1'b0, halt_mode = 1'b0, external_source = 1'b0;
   logic timer2_event = 1'b0, timer1_event = 1'b0, timer0_event = 1'b0;
   logic timer0_stop_event = 1'b0, timer0_stop_mode = 1'b0;
   logic irq_mask, take_ack, return_req, pc_load_valid;
   logic [15:0] cur_pc, pc_load, p, v;
   logic [5:0] src_taken, s;
   int n_fail = 0, n_checks = 0, seed = 12264, c;
   int ftap[8] = '{10, 8, 6, 4, 3, 2, 1, 0};
   always #10 pclk = ~pclk;
   irq_nmi_controller u_irq_nmi_controller (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
      .pslverr, .slow_clock_en, .halt_mode, .timer2_event, .timer1_event,
      .timer0_event, .timer0_stop_event, .timer0_stop_mode,
      .external_source, .irq_mask, .take_ack, .return_req, .cur_pc,
      .irq_req, .nmi_req, .pc_load, .pc_load_valid, .src_taken);
   cpu_model u_cpu_model (.pclk, .irq_req, .nmi_req, .pc_load,
      .pc_load_valid, .src_taken, .irq_mask, .take_ack, .return_req,
      .cur_pc);
   task results;
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : results
   task tmo;
      n_fail++;
      $display("unexpected timeout");
      results();
   endtask : tmo
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      if (k >= 16) tmo();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(nm, e, rd)
   endtask : rdc
   // bits: stop event, timer0, timer1, timer2
   task ev(input logic [3:0] t);
      {timer0_stop_event, timer0_event, timer1_event, timer2_event} <= t;
      @(posedge pclk);
      {timer0_stop_event, timer0_event, timer1_event, timer2_event} <= 4'h0;
      repeat (2) @(posedge pclk);
   endtask : ev
   task ex(input logic lv, input logic [31:0] e);
      external_source <= lv;
      repeat (4) @(posedge pclk);
      rdc("external", PENDING_ADDR, e);
      apb(1'b1, PENDING_ADDR, 32'h0);
   endtask : ex
   task sc(input int n);
      repeat (n) begin
         slow_clock_en <= 1'b1;
         @(posedge pclk);
         slow_clock_en <= 1'b0;
         repeat (4) @(posedge pclk);
      end
   endtask : sc
   // counts slow periods from a flag clear until the irq shows
   task tm(input int b);
      apb(1'b1, PENDING_ADDR, ~(32'h1 << b));
      c = 0;
      do begin
         sc(1);
         c++;
      end while (irq_req !== 1'b1 && c < 5000);
      if (c >= 5000) tmo();
   endtask : tm
   task svc(input int i);
      p = 16'($random(seed));
      u_cpu_model.enter(p, v, s, ok);
      `CHK("entry", 1'b1, ok)
      `CHK("vector", 16'h07e0 + 16'(2 * i), v)
      `CHK("source", 6'h01 << i, s)
      `CHK("held", 1'b0, irq_req)
      apb(1'b1, PENDING_ADDR, ~(32'h1 << i));
      u_cpu_model.leave(v, ok);
      `CHK("return pc", p, v)
   endtask : svc
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rdc("enable", ENABLE_ADDR, 32'h0);
      rdc("pending", PENDING_ADDR, 32'h0);
      rdc("route", ROUTE_ADDR, 32'h0);
      rdc("tick ctl", TICKCTL_ADDR, 32'h43);
      apb(1'b0, 12'h020, 32'h0);
      `CHK("unmapped", 1'b1, er)
      m = $random(seed);
      apb(1'b1, ROUTE_ADDR, m);
      rdc("route", ROUTE_ADDR, m & 32'h3f);
      apb(1'b1, ROUTE_ADDR, 32'h0);
      pstrb <= 4'he;
      apb(1'b1, ROUTE_ADDR, 32'h3f);
      pstrb <= 4'hf;
      rdc("strobe", ROUTE_ADDR, 32'h0);
      repeat (16) begin
         m = $random(seed);
         apb(1'b1, ENABLE_ADDR, m);
         rdc("enable", ENABLE_ADDR, m & 32'h3f);
         ev({1'b0, m[10:8]});
         flg = flg | m[10:8];
         rdc("pending", PENDING_ADDR, flg);
         `CHK("irq", |(flg & m), irq_req)
         m = $random(seed);
         apb(1'b1, PENDING_ADDR, m);
         flg = flg & m;
      end
      apb(1'b1, PENDING_ADDR, 32'h0);
      timer0_stop_mode <= 1'b1;
      ev(4'h4);
      rdc("stop mode", PENDING_ADDR, 32'h0);
      ev(4'h8);
      rdc("stop event", PENDING_ADDR, 32'h4);
      timer0_stop_mode <= 1'b0;
      ex(1'b1, 32'h24);
      apb(1'b1, TICKCTL_ADDR, 32'h03);
      ex(1'b0, 32'h20);
      ex(1'b1, 32'h00);
      apb(1'b1, TICKCTL_ADDR, 32'h40);
      apb(1'b1, ENABLE_ADDR, 32'h08);
      for (int i = 0; i < 8; i++) begin
         apb(1'b1, TICKCTL_ADDR, 32'h40 | i);
         tm(3);
         tm(3);
         `CHK("fast period", 1 << (ftap[i] + 1), c)
      end
      apb(1'b1, ENABLE_ADDR, 32'h10);
      for (int i = 7; i > 3; i--) begin
         apb(1'b1, TICKCTL_ADDR, 32'h40 | (i << 3));
         tm(4);
         tm(4);
         `CHK("slow period", 1 << (14 - i), c)
      end
      halt_mode <= 1'b1;
      apb(1'b1, TICKCTL_ADDR, 32'h47);
      apb(1'b1, ENABLE_ADDR, 32'h08);
      apb(1'b1, PENDING_ADDR, 32'h0);
      sc(8);
      `CHK("halted", 1'b0, irq_req)
      halt_mode <= 1'b0;
      apb(1'b1, ENABLE_ADDR, 32'h0);
      apb(1'b1, PENDING_ADDR, 32'h0);
      apb(1'b1, ENABLE_ADDR, 32'h3f);
      ev(4'h7);
      for (int i = 0; i < 3; i++) svc(i);
      apb(1'b1, ENABLE_ADDR, 32'h0);
      apb(1'b1, ROUTE_ADDR, 32'h02);
      apb(1'b1, ENABLE_ADDR, 32'h3f);
      ev(4'h3);
      @(posedge pclk);
      `CHK("nmi", 1'b1, nmi_req)
      svc(1);
      svc(0);
      results();
   end
endmodule : test_irq_nmi_controller
